// file: logic/async_serial_tx_baud_gen.sv
// serial unit: baud generator, transmitter, simple receiver, registers
// assumes a register master on sys_clk and rx_pin from outside the domain
`timescale 1ns/1ps
`default_nettype none
`include "serial_cfg.svh"
module async_serial_tx_baud_gen
  import serial_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [2:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic rx_pin,
  input wire logic tx_pin_in,
  output logic tx_pin_out,
  output logic tx_pin_oe_n,
  output logic tx_buf_irq,
  output logic tx_done_irq,
  output logic rx_irq
);
  // ************************************************
  // state
  // ************************************************
  typedef struct packed {
    // software registers
    logic [12:0] baud_divisor;
    logic [15:0] cfg;
    logic port_function_select;
    logic port_direction_reg;
    logic port_output_reg;
    // baud generator
    logic [12:0] div_cnt;
    logic [1:0] pre_cnt;
    logic [3:0] bit_tick_cnt;
    // transmitter
    tx_state_t tx_state;
    frame_kind_t kind;
    logic [10:0] shifter;
    logic [3:0] bits_left;
    logic [8:0] tx_holding_reg;
    logic tx_buffer_empty;
    logic tx_done_flag;
    logic pend_preamble;
    logic tx_active;
    logic tx_on_q;
    logic [5:0] armed;
    // receiver and pin synchronisers
    logic [1:0] pin_sync;
    logic [1:0] rx_sync;
    logic [1:0] ones_cnt;
    logic rx_prev;
    rx_state_t rx_state;
    logic [3:0] rx_phase;
    logic [3:0] rx_bits;
    logic [10:0] rx_shift;
    logic [8:0] rx_data;
    logic rx_full;
    logic parity_error_flag;
    logic frame_err;
    logic overrun;
    // bus read data
    logic [15:0] rdata;
  } state_t;
  state_t s_reg;
  state_t s_next;

  // frame length in bit times
  function automatic logic [3:0] frame_bits(input logic long_frame);
    frame_bits = long_frame ? 4'hB : 4'hA;
  endfunction

  // parity over the data slots below the parity slot
  function automatic logic par_calc(input logic [8:0] d,
                                    input logic long_frame,
                                    input logic odd);
    logic [8:0] m;
    m = long_frame ? 9'h0FF : 9'h07F;
    par_calc = (^(d & m)) ^ odd;
  endfunction

  function automatic logic [5:0] flag_bits(input state_t s);
    flag_bits = {s.overrun, s.frame_err, s.parity_error_flag, s.rx_full,
      s.tx_done_flag, s.tx_buffer_empty};
  endfunction

  logic long_frame;
  logic par_en;
  logic tx_on;
  logic rt_tick;
  logic baud_tick;
  logic flags_rd;
  logic data_wr;
  logic data_rd;
  logic [8:0] data_word;
  logic rx_s;
  logic [3:0] nbits;

  // ************************************************
  // next state
  // ************************************************
  always_comb begin
    s_next = s_reg;
    long_frame = s_reg.cfg[`BIT_LONG_FRAME];
    par_en = s_reg.cfg[`BIT_PARITY_EN];
    tx_on = s_reg.cfg[`BIT_TX_ON];
    nbits = frame_bits(long_frame);
    flags_rd = rd && addr == `OFS_SERIAL_FLAGS;
    data_wr = wr && addr == `OFS_SERIAL_DATA;
    data_rd = rd && addr == `OFS_SERIAL_DATA;
    rt_tick = 1'b0;
    baud_tick = 1'b0;
    rx_s = s_reg.rx_sync[1];
    data_word = 9'h000;

    // ************************************************
    // register writes
    // ************************************************
    if (wr) begin
      unique case (addr)
        `OFS_BAUD_CONTROL: s_next.baud_divisor = wdata[12:0];
        `OFS_SERIAL_CONFIG: s_next.cfg = wdata;
        `OFS_PORT_FUNCTION: s_next.port_function_select = wdata[0];
        `OFS_PORT_DIRECTION: s_next.port_direction_reg = wdata[0];
        `OFS_PORT_OUTPUT: s_next.port_output_reg = wdata[0];
        default: ;
      endcase
    end

    // ************************************************
    // baud generator: divisor counter, /2 prescale, /16 to bit time
    // ************************************************
    // a zero divisor freezes every tick, so nothing moves on the line
    if (s_reg.baud_divisor == 13'h0000) begin
      s_next.div_cnt = 13'h0000;
      s_next.pre_cnt = 2'h0;
    end else if (s_reg.div_cnt >= s_reg.baud_divisor - 13'h0001) begin
      s_next.div_cnt = 13'h0000;
      if (s_reg.pre_cnt == `PRE_DIV - 2'h1) begin
        s_next.pre_cnt = 2'h0;
        rt_tick = 1'b1;
      end else begin
        s_next.pre_cnt = s_reg.pre_cnt + 2'h1;
      end
    end else begin
      s_next.div_cnt = s_reg.div_cnt + 13'h0001;
    end
    if (rt_tick) begin
      s_next.bit_tick_cnt = s_reg.bit_tick_cnt + 4'h1;
      baud_tick = s_reg.bit_tick_cnt == 4'hF;
    end

    // ************************************************
    // transmit buffer: load only while flag was cleared by read/write
    // ************************************************
    s_next.tx_on_q = tx_on;
    if (data_wr) begin
      if (s_reg.armed[`BIT_DONE])
        s_next.tx_done_flag = 1'b0;
      if (s_reg.armed[`BIT_BUF_EMPTY] || !s_reg.tx_buffer_empty) begin
        s_next.tx_holding_reg = wdata[8:0];
        s_next.tx_buffer_empty = 1'b0;
      end
      // a write without clearing the flag first is dropped
      s_next.armed[1:0] = 2'b00;
    end
    if (tx_on && !s_reg.tx_on_q)
      s_next.pend_preamble = 1'b1;
    // disabling lets the frame finish but drops the waiting word
    if (!tx_on && s_reg.tx_on_q) begin
      s_next.tx_buffer_empty = 1'b1;
      s_next.pend_preamble = 1'b0;
    end

    // ************************************************
    // transmitter
    // ************************************************
    if (baud_tick) begin
      unique case (s_reg.tx_state)
        TX_FRAME: begin
          s_next.shifter = {1'b1, s_reg.shifter[10:1]};
          s_next.bits_left = s_reg.bits_left - 4'h1;
          if (s_reg.bits_left == 4'h1) begin
            if (s_reg.kind == KIND_BREAK && !(tx_on &&
                s_reg.cfg[`BIT_SEND_BREAK])) begin
              s_next.tx_state = TX_MARK;
              s_next.shifter = 11'h7FF;
            end else begin
              s_next.tx_state = TX_IDLE;
            end
          end
        end
        TX_MARK: s_next.tx_state = TX_IDLE;
        default: ;
      endcase
    end
    // next frame on a bit tick only, so a start bit is a full bit time
    if (s_next.tx_state == TX_IDLE && baud_tick) begin
      s_next.tx_active = 1'b0;
      if (!tx_on) begin
        if (s_reg.tx_active)
          s_next.tx_done_flag = 1'b1;
      end else if (s_next.pend_preamble) begin
        s_next.pend_preamble = 1'b0;
        s_next.kind = KIND_IDLE;
        s_next.shifter = 11'h7FF;
        s_next.bits_left = nbits;
        s_next.tx_state = TX_FRAME;
        s_next.tx_active = 1'b1;
      end else if (s_reg.cfg[`BIT_SEND_BREAK]) begin
        s_next.kind = KIND_BREAK;
        s_next.shifter = 11'h000;
        s_next.bits_left = nbits;
        s_next.tx_state = TX_FRAME;
        s_next.tx_active = 1'b1;
      end else if (!s_next.tx_buffer_empty) begin
        data_word = s_next.tx_holding_reg;
        if (par_en) begin
          if (long_frame)
            data_word[8] = par_calc(data_word, 1'b1,
              s_reg.cfg[`BIT_PARITY_ODD]);
          else
            data_word[7] = par_calc(data_word, 1'b0,
              s_reg.cfg[`BIT_PARITY_ODD]);
        end
        s_next.kind = KIND_DATA;
        s_next.shifter = long_frame ? {1'b1, data_word, 1'b0} :
          {2'b11, data_word[7:0], 1'b0};
        s_next.bits_left = nbits;
        s_next.tx_state = TX_FRAME;
        s_next.tx_active = 1'b1;
        s_next.tx_buffer_empty = 1'b1;
      end else if (s_reg.tx_active || s_reg.tx_state != TX_IDLE) begin
        s_next.tx_done_flag = 1'b1;
      end
    end
    if (s_next.tx_active || s_next.tx_state != TX_IDLE)
      s_next.tx_done_flag = 1'b0;
    else if (tx_on && !s_next.pend_preamble && s_next.tx_buffer_empty &&
             s_reg.tx_state != TX_IDLE)
      s_next.tx_done_flag = 1'b1;

    // ************************************************
    // flag clearing
    // ************************************************
    // clears go ahead of the receiver, so a flag set this cycle survives
    if (data_rd) begin
      s_next.rx_full = s_next.rx_full & ~s_reg.armed[`BIT_RX_FULL];
      s_next.parity_error_flag = s_next.parity_error_flag &
        ~s_reg.armed[`BIT_PARITY_ERR];
      s_next.frame_err = s_next.frame_err & ~s_reg.armed[`BIT_FRAME_ERR];
      s_next.overrun = s_next.overrun & ~s_reg.armed[`BIT_OVERRUN];
      s_next.armed[5:2] = 4'h0;
    end
    if (flags_rd)
      s_next.armed = flag_bits(s_reg);

    // ************************************************
    // receiver: 16 samples per bit, start qualified by three high samples
    // ************************************************
    s_next.rx_sync = {s_reg.rx_sync[0], rx_pin};
    // the pin readback is synchronised like the receive pin
    s_next.pin_sync = {s_reg.pin_sync[0], tx_pin_in};
    if (rt_tick) begin
      s_next.rx_prev = rx_s;
      if (rx_s)
        s_next.ones_cnt = (s_reg.ones_cnt == `START_QUAL) ?
          s_reg.ones_cnt : s_reg.ones_cnt + 2'h1;
      else
        s_next.ones_cnt = 2'h0;
      unique case (s_reg.rx_state)
        RX_IDLE: begin
          if (s_reg.cfg[`BIT_RX_ON] && !rx_s && s_reg.rx_prev &&
              s_reg.ones_cnt == `START_QUAL) begin
            s_next.rx_state = RX_FRAME;
            s_next.rx_phase = 4'h1;
            s_next.rx_bits = 4'h0;
          end
        end
        RX_FRAME: begin
          s_next.rx_phase = s_reg.rx_phase + 4'h1;
          if (rx_s != s_reg.rx_prev)
            s_next.rx_phase = 4'h1;
          if (s_reg.rx_phase == 4'h8) begin
            s_next.rx_shift = {rx_s, s_reg.rx_shift[10:1]};
            s_next.rx_bits = s_reg.rx_bits + 4'h1;
            if (s_reg.rx_bits == nbits - 4'h1) begin
              s_next.rx_state = RX_IDLE;
              // a full buffer keeps the older word
              if (s_reg.rx_full) begin
                s_next.overrun = 1'b1;
              end else begin
                s_next.rx_full = 1'b1;
                s_next.rx_data = long_frame ? s_next.rx_shift[9:1] :
                  {1'b0, s_next.rx_shift[10:3]};
                s_next.frame_err = !rx_s;
                s_next.parity_error_flag = par_en &&
                  (par_calc(s_next.rx_data, long_frame, 1'b0) ^
                  (long_frame ? s_next.rx_data[8] : s_next.rx_data[7]) ^
                  s_reg.cfg[`BIT_PARITY_ODD]);
              end
            end
          end
        end
        default: s_next.rx_state = RX_IDLE;
      endcase
    end

    // ************************************************
    // read data, one cycle after the strobe
    // ************************************************
    s_next.rdata = 16'h0000;
    if (rd) begin
      unique case (addr)
        `OFS_BAUD_CONTROL: s_next.rdata = {3'h0, s_reg.baud_divisor};
        `OFS_SERIAL_CONFIG: s_next.rdata = s_reg.cfg;
        `OFS_SERIAL_FLAGS: s_next.rdata = {10'h000, flag_bits(s_reg)};
        `OFS_SERIAL_DATA: s_next.rdata = {7'h00, s_reg.rx_data};
        `OFS_PORT_FUNCTION: s_next.rdata = {15'h0000,
          s_reg.port_function_select};
        `OFS_PORT_DIRECTION: s_next.rdata = {15'h0000,
          s_reg.port_direction_reg};
        `OFS_PORT_OUTPUT: s_next.rdata = {15'h0000, s_reg.pin_sync[1]};
        default: s_next.rdata = 16'h0000;
      endcase
    end
  end

  // ************************************************
  // state register
  // ************************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_reg <= '0;
      s_reg.baud_divisor <= `RST_DIVISOR;
      s_reg.cfg <= `RST_CONFIG;
      s_reg.shifter <= 11'h7FF;
      s_reg.tx_buffer_empty <= 1'b1;
      s_reg.tx_done_flag <= 1'b1;
      s_reg.rx_sync <= 2'b11;
      s_reg.rx_prev <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ************************************************
  // pins and requests
  // ************************************************
  logic serial_owns;
  logic pin_level;
  logic pin_drive;
  assign serial_owns = s_reg.cfg[`BIT_TX_ON] ||
    s_reg.tx_state != TX_IDLE;
  assign pin_level = serial_owns ? s_reg.shifter[0] : s_reg.port_output_reg;
  assign pin_drive = serial_owns ||
    (s_reg.port_function_select == 1'b0 && s_reg.port_direction_reg);
  // open drain: pull low only, the line's pull-up makes the one
  assign tx_pin_out = s_reg.cfg[`BIT_OPEN_DRAIN] ? 1'b0 : pin_level;
  assign tx_pin_oe_n = !(pin_drive && (!s_reg.cfg[`BIT_OPEN_DRAIN] ||
    !pin_level));

  // ************************************************
  // requests
  // ************************************************
  assign tx_buf_irq = s_reg.tx_buffer_empty &&
    s_reg.cfg[`BIT_BUF_IRQ_EN];
  assign tx_done_irq = s_reg.tx_done_flag && s_reg.cfg[`BIT_DONE_IRQ_EN];
  assign rx_irq = s_reg.rx_full && s_reg.cfg[`BIT_RX_IRQ_EN];
  assign rdata = s_reg.rdata;
endmodule
`default_nettype wire

// file: logic/serial_cfg.svh
// register offsets, field positions, reset values and counts for the serial unit
// assumes the includer sits on a single 25 MHz system clock
// Functional notes
// - frames open with one zero bit, close with a one bit; 10 or 11 bits long.
// - start bit needs a falling edge after three or more high samples.
// - data goes out least significant bit first; base format 1+8+1.
// - long-frame select and parity enable give 8, 7+P, 9 or 8+P data bits.
// - baud is sys clock over 32 times a 13-bit divisor, 1 to 8191.
// - divisor zero stops both baud and sample ticks.
// - sample tick runs at 16x baud; receiver realigns on each line edge.
// - parity select clear means even, set means odd, both directions.
// - parity enabled: top data slot carries parity; mismatch sets parity error.
// - holding register ahead of the shifter; transmitter runs while enabled.
// - shifter drives the pin while enabled or while a frame still runs.
// - open-drain select picks pin drive style for serial and port use alike.
// - buffer-empty low while a word waits; rewrite overwrites; sets on transfer.
// - done flag low while shifting; also cleared by flags read then data write.
// - enabling sends an idle preamble now or after the current frame.
// - send-break emits whole zero frames until break or enable drops.
// - after a break at least one bit time of mark is sent.
// - enabled and nothing pending: both flags set and pin held high.
// - disabling finishes frames, drops the buffered word, returns pin to port.
// - re-enable before shifter empties: finish, preamble, then idle or continue.
// - buffer-empty and done flags each raise a request when enabled.
// - flags clear by a flags read followed by a data access.
`ifndef SERIAL_CFG_SVH
`define SERIAL_CFG_SVH
`define OFS_BAUD_CONTROL 3'h0
`define OFS_SERIAL_CONFIG 3'h2
`define OFS_SERIAL_FLAGS 3'h4
`define OFS_SERIAL_DATA 3'h6
`define OFS_PORT_FUNCTION 3'h1
`define OFS_PORT_DIRECTION 3'h3
`define OFS_PORT_OUTPUT 3'h5
`define BIT_PARITY_ODD 0
`define BIT_PARITY_EN 1
`define BIT_LONG_FRAME 2
`define BIT_OPEN_DRAIN 3
`define BIT_SEND_BREAK 4
`define BIT_TX_ON 5
`define BIT_RX_ON 6
`define BIT_BUF_IRQ_EN 7
`define BIT_DONE_IRQ_EN 8
`define BIT_RX_IRQ_EN 9
`define BIT_BUF_EMPTY 0
`define BIT_DONE 1
`define BIT_RX_FULL 2
`define BIT_PARITY_ERR 3
`define BIT_FRAME_ERR 4
`define BIT_OVERRUN 5
`define RST_DIVISOR 13'h0004
`define RST_CONFIG 16'h0000
`define SAMPLES_PER_BIT 5'h10
`define PRE_DIV 2'h2
`define START_QUAL 2'h3
`endif

// file: logic/serial_pkg.sv
// types of the serial unit
// assumes nothing beyond its own declarations
package serial_pkg;
  typedef enum logic [1:0] {
    TX_IDLE,
    TX_FRAME,
    TX_MARK
  } tx_state_t;
  typedef enum logic [1:0] {
    RX_IDLE,
    RX_FRAME
  } rx_state_t;
  typedef enum logic [1:0] {
    KIND_DATA,
    KIND_IDLE,
    KIND_BREAK
  } frame_kind_t;
endpackage

// file: verif/serial_monitor.sv
// port assertions for the serial transmitter and baud generator
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
`default_nettype none
`include "serial_cfg.svh"
module serial_monitor (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [2:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic tx_pin_out,
  input wire logic tx_pin_oe_n,
  input wire logic tx_buf_irq,
  input wire logic tx_done_irq
);
  localparam int MAX_OFF = 1000;
  logic [12:0] div_reg;
  logic [15:0] cfg_reg;
  logic [15:0] dir_reg;
  logic [18:0] run_reg;
  logic seen_reg, pin_reg, oe_reg, chg;
  // ****************
  // shadow registers
  // ****************
  assign chg = !tx_pin_oe_n && !oe_reg && tx_pin_out != pin_reg;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      div_reg <= `RST_DIVISOR;
      cfg_reg <= `RST_CONFIG;
      dir_reg <= 16'h0000;
      run_reg <= 19'h00000;
      seen_reg <= 1'b0;
    end else begin
      if (wr && addr == `OFS_BAUD_CONTROL) div_reg <= wdata[12:0];
      if (wr && addr == `OFS_SERIAL_CONFIG) cfg_reg <= wdata;
      if (wr && addr == `OFS_PORT_DIRECTION) dir_reg <= wdata;
      // cycles the present line level has held, saturating
      run_reg <= chg ? 19'h00001 : run_reg + {18'h00000, ~&run_reg};
      seen_reg <= tx_pin_oe_n ? 1'b0 : (seen_reg | chg);
    end
    pin_reg <= tx_pin_out;
    oe_reg <= tx_pin_oe_n;
  end
  // **********
  // properties
  // **********
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence start_edge;
    cfg_reg[`BIT_TX_ON] && !tx_pin_oe_n && $fell(tx_pin_out);
  endsequence
  sequence held_low;
    !tx_pin_out [*8];
  endsequence
  a_start_bit_low: assert property (start_edge |=> held_low)
    else $error("start bit too short");
  a_bit_length: assert property (
    chg && seen_reg |-> run_reg >= {1'b0, div_reg, 5'h00})
    else $error("bit shorter than 32 times divisor");
  a_baud_stop: assert property (
    div_reg == 13'h0000 && $stable(div_reg) && !tx_pin_oe_n
    && cfg_reg[`BIT_TX_ON] |=> $stable(tx_pin_out) || tx_pin_oe_n)
    else $error("line moved with divisor zero");
  a_open_drain: assert property (
    cfg_reg[`BIT_OPEN_DRAIN] && $past(cfg_reg[`BIT_OPEN_DRAIN])
    && !tx_pin_oe_n |-> !tx_pin_out)
    else $error("open drain pin driven high");
  a_enable_drive: assert property (
    $rose(cfg_reg[`BIT_TX_ON]) && $past(tx_pin_oe_n) && div_reg == 13'h0001
    && !cfg_reg[`BIT_OPEN_DRAIN] |-> ##[1:40] !tx_pin_oe_n && tx_pin_out)
    else $error("enable did not drive mark");
  a_release_pin: assert property (
    $fell(cfg_reg[`BIT_TX_ON]) && !cfg_reg[`BIT_SEND_BREAK]
    && dir_reg == 16'h0000 && div_reg == 13'h0001
    |-> ##[1:MAX_OFF] tx_pin_oe_n)
    else $error("pin not released after disable");
  a_buf_irq_gate: assert property (
    tx_buf_irq |-> cfg_reg[`BIT_BUF_IRQ_EN] || $past(cfg_reg[`BIT_BUF_IRQ_EN]))
    else $error("buffer irq without enable");
  a_done_irq_gate: assert property (
    tx_done_irq |-> cfg_reg[`BIT_DONE_IRQ_EN]
    || $past(cfg_reg[`BIT_DONE_IRQ_EN]))
    else $error("done irq without enable");
endmodule
`default_nettype wire

// file: verif/serial_peer.sv
// far-side listener on the shared transmit line
// assumes BIT_CYCLES system clocks per bit and a pull-up on the line
`timescale 1ns/1ps
`default_nettype none
module serial_peer #(
  parameter int BIT_CYCLES = 32
) (
  input wire logic sys_clk,
  input wire logic line,
  input wire logic long_frame,
  output logic [8:0] word,
  output logic stop_ok,
  output int count,
  output logic rx_line
);
  logic [8:0] acc;
  // receive line stays at its pulled-up idle level
  initial begin
    word = 9'h000;
    stop_ok = 1'b0;
    count = 0;
    rx_line = 1'b1;
  end
  always begin
    @(negedge line);
    repeat (BIT_CYCLES / 2) @(posedge sys_clk);
    if (line === 1'b0) begin
      acc = 9'h000;
      for (int i = 0; i < (long_frame ? 9 : 8); i++) begin
        repeat (BIT_CYCLES) @(posedge sys_clk);
        acc[i] = line;
      end
      repeat (BIT_CYCLES) @(posedge sys_clk);
      stop_ok = line;
      word = acc;
      count++;
    end
  end
endmodule
`default_nettype wire

// file: verif/testbench.sv
// self-checking bench for the serial transmitter
// assumes serial_peer on the line and a divisor of one, 32 cycles a bit
`timescale 1ns/1ps
`default_nettype none
`include "serial_cfg.svh"
module testbench;
  typedef struct {logic [15:0] cfg; logic [8:0] data; logic [8:0] exp;} row_t;
  logic sys_clk = 0, sys_rst = 1, wr = 0, rd = 0, peer_long = 0;
  logic [2:0] addr = 3'h0;
  logic [15:0] wdata = 16'h0000, rdata, v;
  logic tx_pin_out, tx_pin_oe_n, tx_buf_irq, tx_done_irq, rx_irq;
  logic rx_line, stop_ok;
  logic [8:0] word;
  int count, c0, n, failures = 0, tests_run = 0, cycles = 0;
  wire logic line = tx_pin_oe_n ? 1'b1 : tx_pin_out;
  row_t rows [7] = '{'{16'h0020, 9'h0A5, 9'h0A5}, '{16'h0022, 9'h053, 9'h053},
    '{16'h0023, 9'h053, 9'h0D3}, '{16'h0024, 9'h1C3, 9'h1C3},
    '{16'h0026, 9'h0F1, 9'h1F1}, '{16'h0027, 9'h0F1, 9'h0F1},
    '{16'h0028, 9'h03C, 9'h03C}};
  async_serial_tx_baud_gen dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .rx_pin(rx_line), .tx_pin_in(line), .tx_pin_out(tx_pin_out),
    .tx_pin_oe_n(tx_pin_oe_n), .tx_buf_irq(tx_buf_irq),
    .tx_done_irq(tx_done_irq), .rx_irq(rx_irq));
  serial_peer #(.BIT_CYCLES(32)) peer (.sys_clk(sys_clk), .line(line),
    .long_frame(peer_long), .word(word), .stop_ok(stop_ok),
    .count(count), .rx_line(rx_line));
  always #20 sys_clk = ~sys_clk;
  // *****
  // tasks
  // *****
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(negedge sys_clk);
    d = rdata;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic send(input logic [8:0] d);
    rd_reg(`OFS_SERIAL_FLAGS, v);
    wr_reg(`OFS_SERIAL_DATA, {7'h00, d});
  endtask
  task automatic wait_idle;
    n = 0;
    do begin
      rd_reg(`OFS_SERIAL_FLAGS, v);
      n++;
    end while (v[1:0] !== 2'h3 && n < 400);
    chk("idle flags", 16'h0003, {14'h0000, v[1:0]});
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      give_verdict();
    end
  end
  // ********
  // sequence
  // ********
  initial begin
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd_reg(`OFS_BAUD_CONTROL, v);
    chk("divisor", {3'h0, `RST_DIVISOR}, v);
    rd_reg(`OFS_SERIAL_CONFIG, v);
    chk("config", `RST_CONFIG, v);
    rd_reg(`OFS_SERIAL_FLAGS, v);
    chk("flags", 16'h0003, v);
    rd_reg(3'h7, v);
    chk("unmapped", 16'h0000, v);
    $display("reset test done");
    wr_reg(`OFS_BAUD_CONTROL, 16'h0001);
    foreach (rows[i]) begin
      peer_long <= rows[i].cfg[`BIT_LONG_FRAME];
      wr_reg(`OFS_SERIAL_CONFIG, rows[i].cfg);
      wait_idle();
      c0 = count;
      send(rows[i].data);
      wait_idle();
      chk("frames", 16'h0001, 16'(count - c0));
      chk("word", {7'h00, rows[i].exp}, {7'h00, word});
      chk("stop", 16'h0001, {15'h0000, stop_ok});
      $display("frame test %0d done", i);
    end
    peer_long <= 1'b0;
    wr_reg(`OFS_SERIAL_CONFIG, 16'h0020);
    c0 = count;
    send(9'h011);
    repeat (40) @(posedge sys_clk);
    send(9'h022);
    send(9'h033);
    rd_reg(`OFS_SERIAL_FLAGS, v);
    chk("busy flags", 16'h0000, {14'h0000, v[1:0]});
    wait_idle();
    chk("frames", 16'h0002, 16'(count - c0));
    chk("word", 16'h0033, {7'h00, word});
    $display("buffer test done");
    c0 = count;
    wr_reg(`OFS_SERIAL_CONFIG, 16'h0030);
    repeat (40) @(posedge sys_clk);
    wr_reg(`OFS_SERIAL_CONFIG, 16'h0020);
    wait_idle();
    chk("break", 16'h0000, {6'h00, stop_ok, word});
    chk("break frames", 16'h0001, 16'(count - c0));
    chk("mark", 16'h0001, {15'h0000, line});
    $display("break test done");
    wr_reg(`OFS_BAUD_CONTROL, 16'h0000);
    c0 = count;
    send(9'h0A5);
    repeat (400) @(posedge sys_clk);
    chk("stopped", 16'h0000, 16'(count - c0));
    wr_reg(`OFS_BAUD_CONTROL, 16'h0001);
    wait_idle();
    chk("resumed", 16'h0001, 16'(count - c0));
    wr_reg(`OFS_SERIAL_CONFIG, 16'h01A0);
    repeat (2) @(negedge sys_clk);
    chk("irqs", 16'h0003, {13'h0, rx_irq, tx_buf_irq, tx_done_irq});
    wr_reg(`OFS_SERIAL_CONFIG, 16'h00A0);
    repeat (2) @(negedge sys_clk);
    chk("irqs", 16'h0002, {13'h0, rx_irq, tx_buf_irq, tx_done_irq});
    $display("irq test done");
    c0 = count;
    send(9'h05A);
    repeat (40) @(posedge sys_clk);
    send(9'h0C3);
    wr_reg(`OFS_SERIAL_CONFIG, 16'h0000);
    repeat (400) @(posedge sys_clk);
    chk("frames", 16'h0001, 16'(count - c0));
    chk("word", 16'h005A, {7'h00, word});
    chk("released", 16'h0001, {15'h0000, tx_pin_oe_n});
    rd_reg(`OFS_SERIAL_FLAGS, v);
    chk("off flags", 16'h0003, {14'h0000, v[1:0]});
    $display("disable test done");
    give_verdict();
  end
endmodule
bind async_serial_tx_baud_gen serial_monitor mon (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr),
  .tx_pin_out(tx_pin_out), .tx_pin_oe_n(tx_pin_oe_n),
  .tx_buf_irq(tx_buf_irq), .tx_done_irq(tx_done_irq));
`default_nettype wire
